/* File: inc/reset_init_map.svh */
// Register indices, flag positions, reset images and restart addresses for reset handling
`ifndef RESET_INIT_MAP_SVH
`define RESET_INIT_MAP_SVH

`define RIM_ADDR_W 5
`define RIM_NUM_REGS 23

`define RIM_IDX_RET_TOP_U 5'h00
`define RIM_IDX_RET_TOP_H 5'h01
`define RIM_IDX_RET_TOP_L 5'h02
`define RIM_IDX_STACK_INDEX 5'h03
`define RIM_IDX_PC_LATCH_U 5'h04
`define RIM_IDX_PC_LATCH_H 5'h05
`define RIM_IDX_PC_LOW 5'h06
`define RIM_IDX_TBL_PTR_U 5'h07
`define RIM_IDX_TBL_PTR_H 5'h08
`define RIM_IDX_TBL_PTR_L 5'h09
`define RIM_IDX_TBL_LATCH 5'h0a
`define RIM_IDX_PROD_H 5'h0b
`define RIM_IDX_PROD_L 5'h0c
`define RIM_IDX_IRQ_MAIN 5'h0d
`define RIM_IDX_IRQ_SECOND 5'h0e
`define RIM_IDX_IRQ_THIRD 5'h0f
`define RIM_IDX_IND0_H 5'h10
`define RIM_IDX_IND0_L 5'h11
`define RIM_IDX_WORKING 5'h12
`define RIM_IDX_IND1_H 5'h13
`define RIM_IDX_IND1_L 5'h14
`define RIM_IDX_BANK 5'h15
`define RIM_IDX_CAUSE 5'h16

// Reset cause register bit positions
`define RIM_BIT_SHADOW_CMP 5
`define RIM_BIT_SOFT_RST 4
`define RIM_BIT_WDOG_EXP 3
`define RIM_BIT_SLEEP_ENT 2
`define RIM_BIT_POWER_UP 1
`define RIM_BIT_SUPPLY_DIP 0

// Stack index bit positions
`define RIM_BIT_STK_FULL 7
`define RIM_BIT_STK_UNF 6

`define RIM_CAUSE_POR_VAL 8'h3c
`define RIM_CAUSE_FORCED 8'h80
`define RIM_CAUSE_MASK 8'hbf
`define RIM_STACK_FORCED 8'h1f
`define RIM_STACK_MASK 8'hdf
`define RIM_IRQ_MAIN_FORCED 8'hfe
`define RIM_IRQ_SECOND_INIT 8'hff
`define RIM_IRQ_THIRD_INIT 8'hc0

`define RIM_RESTART_PC 21'h000000
`define RIM_VEC_HIGH 21'h000008
`define RIM_VEC_LOW 21'h000018
`define RIM_PC_STEP 21'h000002

`endif

/* File: inc/reset_init_pkg.sv */
// Types shared by the reset cause and register init block
package reset_init_pkg;
  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_RUN_MANAGED = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_SLEEP = 2'b11
  } pwr_mode_t;

  typedef enum logic [1:0] {
    CLASS_NONE = 2'b00,
    CLASS_POWER = 2'b01,
    CLASS_WARM = 2'b10,
    CLASS_WAKE = 2'b11
  } init_class_t;

  typedef enum logic [3:0] {
    CAUSE_NONE = 4'b0000,
    CAUSE_POR = 4'b0001,
    CAUSE_BOR = 4'b0010,
    CAUSE_DSWAKE = 4'b0011,
    CAUSE_MISMATCH = 4'b0100,
    CAUSE_WDOG = 4'b0101,
    CAUSE_EXT_PIN = 4'b0110,
    CAUSE_STK_FULL = 4'b0111,
    CAUSE_STK_UNF = 4'b1000,
    CAUSE_SOFT = 4'b1001,
    CAUSE_IRQ = 4'b1010
  } cause_t;
endpackage : reset_init_pkg

/* File: core/reset_cause_and_register_init.sv */
// Reset cause flags, restart address choice and core register initialisation
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "reset_init_map.svh"

module reset_cause_and_register_init
  import reset_init_pkg::*;
#(
  parameter int PC_W = 21
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic deep_sleep_wake,
  input wire logic mismatch_event,
  input wire logic watchdog_expiry,
  input wire logic external_reset_pin,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic soft_reset_instr,
  input wire logic irq_wake,
  input wire logic irq_is_high,
  input wire logic stack_error_reset_enable,
  input wire logic high_priority_global_irq_enable,
  input wire logic low_priority_global_irq_enable,
  input wire reset_init_pkg::pwr_mode_t pwr_mode,
  input wire logic [PC_W-1:0] current_pc,
  input wire logic [`RIM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic restart_valid,
  output logic [PC_W-1:0] restart_pc,
  output reset_init_pkg::init_class_t init_class
);
  import reset_init_pkg::*;

  // ****************************************************************
  // Per-register tables
  // ****************************************************************
  function automatic logic [7:0] width_mask(input int idx);
    case (idx)
      `RIM_IDX_RET_TOP_U, `RIM_IDX_PC_LATCH_U: width_mask = 8'h1f;
      `RIM_IDX_TBL_PTR_U: width_mask = 8'h3f;
      `RIM_IDX_IND0_H, `RIM_IDX_IND1_H, `RIM_IDX_BANK: width_mask = 8'h0f;
      `RIM_IDX_STACK_INDEX: width_mask = `RIM_STACK_MASK;
      `RIM_IDX_CAUSE: width_mask = `RIM_CAUSE_MASK;
      default: width_mask = 8'hff;
    endcase
  endfunction : width_mask

  // Bits forced on power and warm classes; all others keep their value
  function automatic logic [7:0] forced_mask(input int idx);
    case (idx)
      `RIM_IDX_PROD_H, `RIM_IDX_PROD_L, `RIM_IDX_IND0_H, `RIM_IDX_IND0_L,
      `RIM_IDX_WORKING, `RIM_IDX_IND1_H, `RIM_IDX_IND1_L: forced_mask = 8'h00;
      `RIM_IDX_STACK_INDEX: forced_mask = `RIM_STACK_FORCED;
      `RIM_IDX_IRQ_MAIN: forced_mask = `RIM_IRQ_MAIN_FORCED;
      `RIM_IDX_CAUSE: forced_mask = `RIM_CAUSE_FORCED;
      default: forced_mask = width_mask(idx);
    endcase
  endfunction : forced_mask

  function automatic logic [7:0] init_value(input int idx);
    case (idx)
      `RIM_IDX_IRQ_SECOND: init_value = `RIM_IRQ_SECOND_INIT;
      `RIM_IDX_IRQ_THIRD: init_value = `RIM_IRQ_THIRD_INIT;
      `RIM_IDX_CAUSE: init_value = `RIM_CAUSE_POR_VAL;
      default: init_value = 8'h00;
    endcase
  endfunction : init_value

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] regs [`RIM_NUM_REGS];
  logic [7:0] next_regs [`RIM_NUM_REGS];
  logic [7:0] next_reg_rdata;
  logic next_restart_valid;
  logic [PC_W-1:0] next_restart_pc;
  init_class_t next_init_class;
  cause_t cause;
  logic [PC_W-1:0] resume_pc;
  logic irq_vectored;

  assign resume_pc = current_pc + PC_W'(`RIM_PC_STEP);
  assign irq_vectored = high_priority_global_irq_enable | low_priority_global_irq_enable;

  // ****************************************************************
  // Event priority
  // ****************************************************************
  always_comb begin
    if (por_event) begin
      cause = CAUSE_POR;
    end else if (bor_event) begin
      cause = CAUSE_BOR;
    end else if (deep_sleep_wake) begin
      cause = CAUSE_DSWAKE;
    end else if (mismatch_event) begin
      cause = CAUSE_MISMATCH;
    end else if (watchdog_expiry) begin
      cause = CAUSE_WDOG;
    end else if (external_reset_pin) begin
      cause = CAUSE_EXT_PIN;
    end else if (stack_overflow) begin
      cause = CAUSE_STK_FULL;
    end else if (stack_underflow) begin
      cause = CAUSE_STK_UNF;
    end else if (soft_reset_instr) begin
      cause = CAUSE_SOFT;
    end else if (irq_wake) begin
      cause = CAUSE_IRQ;
    end else begin
      cause = CAUSE_NONE;
    end
  end

  // ****************************************************************
  // Next state: software access, class init, then flag updates
  // ****************************************************************
  always_comb begin
    logic [7:0] rc;
    logic [7:0] sk;
    rc = 8'h00;
    sk = 8'h00;
    for (int i = 0; i < `RIM_NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_reg_rdata = 8'h00;
    next_restart_valid = 1'b0;
    next_restart_pc = restart_pc;
    next_init_class = CLASS_NONE;

    if (reg_rd && (reg_addr < `RIM_ADDR_W'(`RIM_NUM_REGS))) begin
      next_reg_rdata = regs[reg_addr];
    end
    // Software write first so a same-cycle hardware event overrides it
    if (reg_wr && (reg_addr < `RIM_ADDR_W'(`RIM_NUM_REGS))) begin
      next_regs[reg_addr] = reg_wdata & width_mask(int'(reg_addr));
    end

    unique case (cause)
      CAUSE_POR, CAUSE_BOR, CAUSE_DSWAKE: next_init_class = CLASS_POWER;
      CAUSE_MISMATCH, CAUSE_EXT_PIN, CAUSE_SOFT: next_init_class = CLASS_WARM;
      CAUSE_WDOG: begin
        if (pwr_mode == MODE_IDLE || pwr_mode == MODE_SLEEP) begin
          next_init_class = CLASS_WAKE;
        end else begin
          next_init_class = CLASS_WARM;
        end
      end
      CAUSE_STK_FULL, CAUSE_STK_UNF: begin
        next_init_class = stack_error_reset_enable ? CLASS_WARM : CLASS_NONE;
      end
      CAUSE_IRQ: next_init_class = CLASS_WAKE;
      CAUSE_NONE: next_init_class = CLASS_NONE;
    endcase

    // Only designated bits are forced; the rest keep content
    if (next_init_class == CLASS_POWER || next_init_class == CLASS_WARM) begin
      for (int i = 0; i < `RIM_NUM_REGS; i++) begin
        next_regs[i] = (next_regs[i] & ~forced_mask(i)) | (init_value(i) & forced_mask(i));
      end
      next_restart_valid = 1'b1;
      next_restart_pc = PC_W'(`RIM_RESTART_PC);
    end else if (next_init_class == CLASS_WAKE) begin
      next_restart_valid = 1'b1;
      next_restart_pc = resume_pc;
      if (cause == CAUSE_IRQ && irq_vectored) begin
        next_restart_pc = irq_is_high ? PC_W'(`RIM_VEC_HIGH) : PC_W'(`RIM_VEC_LOW);
        // Return address goes onto the stack top, index advances
        next_regs[`RIM_IDX_RET_TOP_U] = {3'b000, resume_pc[20:16]};
        next_regs[`RIM_IDX_RET_TOP_H] = resume_pc[15:8];
        next_regs[`RIM_IDX_RET_TOP_L] = resume_pc[7:0];
        next_regs[`RIM_IDX_STACK_INDEX][4:0] = regs[`RIM_IDX_STACK_INDEX][4:0] + 5'h01;
      end
      next_regs[`RIM_IDX_PC_LOW] = next_restart_pc[7:0];
    end

    rc = next_regs[`RIM_IDX_CAUSE];
    sk = next_regs[`RIM_IDX_STACK_INDEX];
    unique case (cause)
      CAUSE_POR: begin
        rc[5:2] = 4'hf;
        rc[`RIM_BIT_POWER_UP] = 1'b0;
        rc[`RIM_BIT_SUPPLY_DIP] = 1'b0;
        sk[`RIM_BIT_STK_FULL] = 1'b0;
        sk[`RIM_BIT_STK_UNF] = 1'b0;
      end
      CAUSE_BOR, CAUSE_DSWAKE: begin
        rc[5:2] = 4'hf;
        rc[`RIM_BIT_SUPPLY_DIP] = 1'b0;
      end
      CAUSE_MISMATCH: rc[`RIM_BIT_SHADOW_CMP] = 1'b0;
      CAUSE_WDOG: begin
        rc[`RIM_BIT_WDOG_EXP] = 1'b0;
        if (next_init_class == CLASS_WAKE) begin
          rc[`RIM_BIT_SLEEP_ENT] = 1'b0;
        end
      end
      CAUSE_EXT_PIN: begin
        unique case (pwr_mode)
          MODE_RUN_MANAGED: rc[`RIM_BIT_WDOG_EXP] = 1'b1;
          MODE_IDLE, MODE_SLEEP: begin
            rc[`RIM_BIT_WDOG_EXP] = 1'b1;
            rc[`RIM_BIT_SLEEP_ENT] = 1'b0;
          end
          MODE_FULL: rc = next_regs[`RIM_IDX_CAUSE];
        endcase
      end
      CAUSE_STK_FULL: sk[`RIM_BIT_STK_FULL] = 1'b1;
      CAUSE_STK_UNF: sk[`RIM_BIT_STK_UNF] = 1'b1;
      CAUSE_SOFT: rc[`RIM_BIT_SOFT_RST] = 1'b0;
      CAUSE_IRQ: rc[`RIM_BIT_SLEEP_ENT] = 1'b0;
      CAUSE_NONE: rc = next_regs[`RIM_IDX_CAUSE];
    endcase
    next_regs[`RIM_IDX_CAUSE] = rc;
    next_regs[`RIM_IDX_STACK_INDEX] = sk;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  for (genvar g = 0; g < `RIM_NUM_REGS; g++) begin : g_reg
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        regs[g] <= init_value(g);
      end else begin
        regs[g] <= next_regs[g];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      restart_valid <= 1'b0;
      restart_pc <= '0;
      init_class <= CLASS_NONE;
    end else begin
      reg_rdata <= next_reg_rdata;
      restart_valid <= next_restart_valid;
      restart_pc <= next_restart_pc;
      init_class <= next_init_class;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [9:0] ev_vec;
  logic lone_ev;
  logic [7:0] cause_q;
  logic [7:0] stack_q;
  assign ev_vec = {por_event, bor_event, deep_sleep_wake, mismatch_event, watchdog_expiry,
                   external_reset_pin, stack_overflow, stack_underflow, soft_reset_instr, irq_wake};
  assign lone_ev = $onehot(ev_vec) && !reg_wr;
  assign cause_q = regs[`RIM_IDX_CAUSE];
  assign stack_q = regs[`RIM_IDX_STACK_INDEX];

  property p_por_flags;
    @(posedge mclk) disable iff (!reset_n)
      por_event && !reg_wr |=> cause_q[5:0] == 6'h3c && stack_q[7:6] == 2'b00
        && restart_pc == '0 && init_class == CLASS_POWER;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_ext_full;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && external_reset_pin && pwr_mode == MODE_FULL
        |=> $stable(cause_q[5:0]) && $stable(stack_q[7:6]) && restart_valid && restart_pc == '0;
  endproperty
  a_ext_full: assert property (p_ext_full) else $error("pin reset altered flags");

  property p_ext_sleep;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && external_reset_pin && pwr_mode == MODE_SLEEP
        |=> cause_q[`RIM_BIT_WDOG_EXP] && !cause_q[`RIM_BIT_SLEEP_ENT];
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("pin reset in sleep flags");

  property p_wdog_wake;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && watchdog_expiry && pwr_mode == MODE_IDLE
        |=> restart_pc == $past(current_pc) + PC_W'(2) && !cause_q[3] && !cause_q[2]
          && init_class == CLASS_WAKE;
  endproperty
  a_wdog_wake: assert property (p_wdog_wake) else $error("watchdog wake wrong");

  property p_wdog_run;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && watchdog_expiry && pwr_mode == MODE_FULL
        |=> !cause_q[`RIM_BIT_WDOG_EXP] && restart_pc == '0 && $stable(cause_q[2]);
  endproperty
  a_wdog_run: assert property (p_wdog_run) else $error("watchdog reset wrong");

  property p_irq_vector;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && irq_wake && high_priority_global_irq_enable && irq_is_high
        |=> restart_pc == PC_W'(8) && !cause_q[`RIM_BIT_SLEEP_ENT];
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("interrupt vector wrong");

  property p_unf_noreset;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && stack_underflow && !stack_error_reset_enable
        |=> stack_q[`RIM_BIT_STK_UNF] && !restart_valid ##1 !restart_valid;
  endproperty
  a_unf_noreset: assert property (p_unf_noreset) else $error("underflow reset");

  property p_mismatch;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && mismatch_event |=> !cause_q[5] && $stable(cause_q[4:0]) && regs[`RIM_IDX_BANK] == 8'h00;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch flags wrong");

  property p_soft;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && soft_reset_instr |=> !cause_q[4] && regs[`RIM_IDX_IRQ_SECOND] == 8'hff;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset wrong");

  property p_ext_run;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && external_reset_pin && pwr_mode == MODE_RUN_MANAGED
        |=> cause_q[`RIM_BIT_WDOG_EXP] && $stable(cause_q[2]) && restart_pc == '0;
  endproperty
  a_ext_run: assert property (p_ext_run) else $error("pin reset in run flags");

  property p_stk_full;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && stack_overflow && stack_error_reset_enable
        |=> stack_q[`RIM_BIT_STK_FULL] && restart_valid && init_class == CLASS_WARM
          && $stable(cause_q[5:0]);
  endproperty
  a_stk_full: assert property (p_stk_full) else $error("stack full reset wrong");

  property p_irq_plain;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && irq_wake && !irq_vectored
        |=> restart_pc == $past(current_pc) + PC_W'(2) && !cause_q[`RIM_BIT_SLEEP_ENT]
          && init_class == CLASS_WAKE;
  endproperty
  a_irq_plain: assert property (p_irq_plain) else $error("interrupt wake wrong");

  property p_bor_keep;
    @(posedge mclk) disable iff (!reset_n)
      lone_ev && bor_event
        |=> !cause_q[`RIM_BIT_SUPPLY_DIP] && $stable(cause_q[1]) && cause_q[5:2] == 4'hf
          && $stable(stack_q[7:6]);
  endproperty
  a_bor_keep: assert property (p_bor_keep) else $error("brown-out flags wrong");

  c_por: cover property (@(posedge mclk) disable iff (!reset_n) por_event ##1 restart_valid);
  c_irq: cover property (@(posedge mclk) disable iff (!reset_n) irq_wake && irq_vectored);
  c_stk: cover property (@(posedge mclk) disable iff (!reset_n) stack_overflow && lone_ev);
  c_wake: cover property (@(posedge mclk) disable iff (!reset_n) init_class == CLASS_WAKE);
endmodule : reset_cause_and_register_init

/* File: tb/reset_cause_and_register_init_bench.sv */
// Self-checking bench for reset cause flags, restart address and register init
`timescale 1ns/1ps
`include "reset_init_map.svh"
`define CHK(got, want) begin n_compared++; if ((got) !== (want)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, want); end end

module reset_cause_and_register_init_bench;
  import reset_init_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] ev = 10'h000;
  logic irq_is_high = 1'b0;
  logic stack_error_reset_enable = 1'b0;
  logic gie_high = 1'b0;
  logic gie_low = 1'b0;
  pwr_mode_t pwr_mode = MODE_FULL;
  logic [20:0] current_pc = 21'h000000;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic restart_valid;
  logic [20:0] restart_pc;
  init_class_t init_class;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 69098;
  logic [7:0] exp_r [0:22];
  logic [20:0] exp_pc;
  logic exp_v;
  init_class_t exp_cls;
  logic m_hi, m_en, m_gh, m_gl;
  pwr_mode_t m_mode;
  logic [20:0] m_pc;

  always #5 mclk = ~mclk;

  reset_cause_and_register_init #(.PC_W(21)) reset_cause_and_register_init_inst (
    .mclk(mclk), .reset_n(reset_n), .por_event(ev[0]), .bor_event(ev[1]),
    .deep_sleep_wake(ev[2]), .mismatch_event(ev[3]), .watchdog_expiry(ev[4]),
    .external_reset_pin(ev[5]), .stack_overflow(ev[6]), .stack_underflow(ev[7]),
    .soft_reset_instr(ev[8]), .irq_wake(ev[9]), .irq_is_high(irq_is_high),
    .stack_error_reset_enable(stack_error_reset_enable),
    .high_priority_global_irq_enable(gie_high), .low_priority_global_irq_enable(gie_low),
    .pwr_mode(pwr_mode), .current_pc(current_pc), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .restart_valid(restart_valid), .restart_pc(restart_pc), .init_class(init_class));

  // ****************************************
  // Expectation model
  // ****************************************
  function automatic logic [7:0] wmask(input logic [4:0] a);
    case (a)
      5'h00, 5'h04: return 8'h1f;
      5'h07: return 8'h3f;
      5'h03: return 8'hdf;
      5'h10, 5'h13, 5'h15: return 8'h0f;
      default: return 8'hff;
    endcase
  endfunction : wmask

  task automatic init_model();
    for (int i = 0; i < 23; i++) exp_r[i] = 8'h00;
    exp_r[14] = 8'hff;
    exp_r[15] = 8'hc0;
    exp_r[22] = 8'h3c;
    exp_pc = 21'h000000;
  endtask : init_model

  task automatic model(input logic [9:0] e);
    int k;
    logic [7:0] c, s;
    logic [20:0] nx;
    k = -1;
    for (int i = 9; i >= 0; i--) if (e[i]) k = i;
    exp_v = 1'b0;
    exp_cls = CLASS_NONE;
    if (k < 0) return;
    c = exp_r[22];
    s = exp_r[3];
    nx = m_pc + 21'h000002;
    exp_v = 1'b1;
    exp_cls = CLASS_WARM;
    case (k)
      0: begin c = 8'h3c; s = 8'h00; exp_cls = CLASS_POWER; end
      1, 2: begin c = (c & 8'h02) | 8'h3c; exp_cls = CLASS_POWER; end
      3: c[5] = 1'b0;
      4: begin
        c[3] = 1'b0;
        if (m_mode inside {MODE_IDLE, MODE_SLEEP}) begin
          c[2] = 1'b0;
          exp_cls = CLASS_WAKE;
          exp_pc = nx;
        end
      end
      5: begin
        if (m_mode != MODE_FULL) c[3] = 1'b1;
        if (m_mode inside {MODE_IDLE, MODE_SLEEP}) c[2] = 1'b0;
      end
      6: begin s[7] = 1'b1; exp_v = m_en; end
      7: begin s[6] = 1'b1; exp_v = m_en; end
      8: c[4] = 1'b0;
      default: begin
        c[2] = 1'b0;
        exp_cls = CLASS_WAKE;
        exp_pc = nx;
        if (m_gh || m_gl) begin
          exp_pc = m_hi ? `RIM_VEC_HIGH : `RIM_VEC_LOW;
          {exp_r[0], exp_r[1], exp_r[2]} = {3'b000, nx};
          s[4:0] = s[4:0] + 5'h01;
        end
      end
    endcase
    if (!exp_v) exp_cls = CLASS_NONE;
    if (exp_cls == CLASS_POWER || exp_cls == CLASS_WARM) begin
      exp_pc = 21'h000000;
      for (int i = 0; i < 11; i++) exp_r[i] = 8'h00;
      exp_r[13] = exp_r[13] & 8'h01;
      exp_r[14] = 8'hff;
      exp_r[15] = 8'hc0;
      exp_r[21] = 8'h00;
      c[7] = 1'b0;
      s = s & 8'hc0;
    end
    if (exp_cls == CLASS_WAKE) exp_r[6] = exp_pc[7:0];
    exp_r[22] = c;
    exp_r[3] = s;
  endtask : model

  // ****************************************
  // Drivers
  // ****************************************
  task automatic rand_levels();
    m_mode = pwr_mode_t'($random(seed));
    m_pc = $random(seed);
    m_en = $random(seed);
    m_gh = $random(seed);
    m_gl = $random(seed);
    m_hi = $random(seed);
  endtask : rand_levels

  task automatic op(input logic [9:0] e, input logic wr, input logic rd,
                    input logic [4:0] a, input logic [7:0] d);
    logic [7:0] er;
    @(posedge mclk);
    ev <= e;
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    pwr_mode <= m_mode;
    current_pc <= m_pc;
    stack_error_reset_enable <= m_en;
    gie_high <= m_gh;
    gie_low <= m_gl;
    irq_is_high <= m_hi;
    er = (rd && a < 5'h17) ? exp_r[a] : 8'h00;
    model(e);
    if (wr && a == 5'h16) exp_r[22] = d & 8'hbf;
    else if (wr && a < 5'h16) exp_r[a] = d & wmask(a);
    @(posedge mclk);
    ev <= 10'h000;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK(restart_valid, exp_v)
    `CHK(init_class, exp_cls)
    `CHK(restart_pc, exp_pc)
    `CHK(reg_rdata, er)
  endtask : op

  task automatic read_all();
    for (int a = 0; a < 32; a++) op(10'h000, 1'b0, 1'b1, a[4:0], 8'h00);
  endtask : read_all

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [4:0] a;
    int k;
    init_model();
    rand_levels();
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    read_all();
    op(10'h000, 1'b1, 1'b0, 5'h16, 8'h02);
    op(10'h000, 1'b0, 1'b1, 5'h16, 8'h00);
    for (int j = 0; j < 80; j++) begin
      rand_levels();
      m_mode = pwr_mode_t'(j[1:0]);
      m_en = j[2];
      op(10'h001 << (j / 8), 1'b0, 1'b0, 5'h00, 8'h00);
      op(10'h000, 1'b0, 1'b1, 5'h16, 8'h00);
      op(10'h000, 1'b0, 1'b1, 5'h03, 8'h00);
      op(10'h000, 1'b0, 1'b1, 5'h06, 8'h00);
      op(10'h000, 1'b1, 1'b0, 5'h16, $random(seed));
    end
    for (int j = 0; j < 1500; j++) begin
      rand_levels();
      k = $unsigned($random(seed)) % 4;
      a = $random(seed);
      if (k == 0) begin
        if (m_en && a[0]) op($random(seed), 1'b0, 1'b0, 5'h00, 8'h00);
        else op(10'h001 << ($unsigned($random(seed)) % 10), 1'b0, 1'b0, 5'h00, 8'h00);
      end else if (k == 1) begin
        if (a inside {5'h0d, 5'h0f}) a = 5'h16;
        op(10'h000, 1'b1, 1'b0, a, $random(seed));
      end else begin
        op(10'h000, 1'b0, 1'b1, a, 8'h00);
      end
    end
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    init_model();
    read_all();
    give_verdict();
  end
endmodule : reset_cause_and_register_init_bench
